// >>> wbdmu_bench.sv
// self-checking bench of the move unit: table of moves, then pin, register and irq cases
// assumes the execution-unit model drives the operation port
`default_nettype none
module wbdmu_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] op;
    logic [15:0] ctrl;
    logic [15:0] src;
    logic [15:0] dst;
  } wbdmu_row_type;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic opStart, opDstSel, opBusy, opDone, zeroIndicator, signIndicator, faultIndicator, irq;
  logic [2:0] opCode;
  logic [1:0] opSrcSel;
  logic [3:0] opSrcAddr, opDstAddr;
  logic [15:0] opCtrl, outPins, regReadData;
  logic [31:0] opLiteral;
  logic [15:0] inPins = 16'h0000;
  logic [15:0] regWriteData = 16'h0000;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  int numErrors = 0;
  int nCompared = 0;
  wbdmu_row_type rows [15];
  logic [16:0] ex;
  logic [15:0] zv;

  wbdmu_top i_wbdmu_top (.clock(clock), .reset(reset), .opStart(opStart), .opCode(opCode),
    .opSrcSel(opSrcSel), .opDstSel(opDstSel), .opSrcAddr(opSrcAddr), .opDstAddr(opDstAddr),
    .opCtrl(opCtrl), .opLiteral(opLiteral), .opBusy(opBusy), .opDone(opDone),
    .zeroIndicator(zeroIndicator), .signIndicator(signIndicator),
    .faultIndicator(faultIndicator), .inPins(inPins), .outPins(outPins), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .irq(irq));
  wbdmu_exec_model i_wbdmu_exec_model (.clock(clock), .reset(reset), .opStart(opStart),
    .opCode(opCode), .opSrcSel(opSrcSel), .opDstSel(opDstSel), .opSrcAddr(opSrcAddr),
    .opDstAddr(opDstAddr), .opCtrl(opCtrl), .opLiteral(opLiteral), .opBusy(opBusy),
    .opDone(opDone));

  always #25 clock = ~clock;

  // expected destination word with the fault flag on top
  function automatic logic [16:0] refMove(input logic [2:0] op, input logic [15:0] c,
      input logic [15:0] s, input logic [15:0] d);
    logic [15:0] r;
    logic f;
    r = d;
    f = 1'b0;
    case (op)
      3'h0: r = s;
      3'h2: r = ~s;
      3'h4: begin
        f = (c[7:0] > 8'h0f) || (c[15:8] > 8'h0f);
        if (!f) r[c[11:8]] = s[c[3:0]];
      end
      default: begin
        f = (c[3:0] > 4'h3) || (c[7:4] > 4'h3) || (c[11:8] > 4'h3);
        for (int i = 0; i < 4; i++) begin
          if (!f && i <= c[7:4]) r[{c[9:8] + 2'(i), 2'b00} +: 4] = s[{c[1:0] + 2'(i), 2'b00} +: 4];
        end
      end
    endcase
    return {f, r};
  endfunction

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic runOp(input logic [2:0] op, input logic [1:0] ss, input logic ds,
      input logic [3:0] sa, input logic [3:0] da, input logic [15:0] c,
      input logic [31:0] lit, input int expEdges);
    int edges;
    i_wbdmu_exec_model.issue(op, ss, ds, sa, da, c, lit, edges);
    check16(16'(edges), 16'(expEdges));
    if (edges == 0 && expEdges != 0) stopTest();
  endtask
  task automatic load(input logic [3:0] a, input logic [15:0] v);
    runOp(3'h0, 2'h1, 1'b0, 4'h0, a, 16'h0000, {16'h0000, v}, 3);
  endtask
  // copies a stored word to the output pins and compares it there
  task automatic pinsOf(input logic [3:0] a, input logic [15:0] exp);
    runOp(3'h3, 2'h0, 1'b1, a, 4'h0, 16'h0000, 32'h0, 3);
    check16(outPins, exp);
  endtask
  task automatic regWr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic regChk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check16(regReadData, exp);
  endtask
  task automatic stopTest;
    $display("errors %0d, comparisons %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rows = '{'{3'h0, 16'h0000, 16'h0000, 16'h5555}, '{3'h0, 16'h0000, 16'h8001, 16'h0000},
      '{3'h2, 16'h0000, 16'h0000, 16'h1111}, '{3'h2, 16'h0000, 16'hffff, 16'h0000},
      '{3'h4, 16'h0c05, 16'h0020, 16'h0000}, '{3'h4, 16'h0f00, 16'h0000, 16'hffff},
      '{3'h4, 16'h000f, 16'h8000, 16'h8000}, '{3'h4, 16'h0010, 16'hffff, 16'h0000},
      '{3'h4, 16'h1000, 16'hffff, 16'h0000}, '{3'h5, 16'h0031, 16'h4321, 16'h0000},
      '{3'h5, 16'hf203, 16'h4321, 16'hffff}, '{3'h5, 16'h0130, 16'habcd, 16'h0000},
      '{3'h5, 16'h0004, 16'h4321, 16'h9999}, '{3'h5, 16'h0040, 16'h4321, 16'h9999},
      '{3'h5, 16'h0400, 16'h4321, 16'h9999}};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    regChk(8'h00, 16'h0001);
    regChk(8'h0c, 16'h0000);
    regChk(8'h20, 16'h0000);
    regWr(8'h04, 16'h0007);
    regChk(8'h04, 16'h0000);
    foreach (rows[i]) begin
      load(4'h1, rows[i].src);
      load(4'h2, rows[i].dst);
      runOp(rows[i].op, 2'h0, 1'b0, 4'h1, 4'h2, rows[i].ctrl, 32'h0, 3);
      ex = refMove(rows[i].op, rows[i].ctrl, rows[i].src, rows[i].dst);
      zv = (rows[i].op < 3'h4) ? ex[15:0] : rows[i].dst;
      check1(faultIndicator, ex[16]);
      check1(zeroIndicator, zv == 16'h0000);
      check1(signIndicator, zv[15]);
      pinsOf(4'h1, rows[i].src);
      pinsOf(4'h2, ex[15:0]);
    end
    // double copy wrapping from word 15 to word 0
    runOp(3'h1, 2'h1, 1'b0, 4'h0, 4'hf, 16'h0000, 32'hf000_8000, 4);
    check1(signIndicator, 1'b1);
    check1(zeroIndicator, 1'b0);
    pinsOf(4'hf, 16'h8000);
    pinsOf(4'h0, 16'hf000);
    runOp(3'h1, 2'h0, 1'b0, 4'hf, 4'h8, 16'h0000, 32'h0, 4);
    pinsOf(4'h8, 16'h8000);
    pinsOf(4'h9, 16'hf000);
    runOp(3'h1, 2'h1, 1'b0, 4'h0, 4'h6, 16'h0000, 32'h0, 4);
    check1(zeroIndicator, 1'b1);
    check1(signIndicator, 1'b0);
    // immediate copy from input pins straight to output pins, then into the store
    @(posedge clock);
    inPins <= 16'ha55a;
    repeat (6) @(posedge clock);
    runOp(3'h3, 2'h2, 1'b1, 4'h0, 4'h0, 16'h0000, 32'h0, 3);
    check16(outPins, 16'ha55a);
    @(posedge clock);
    inPins <= 16'h0ff0;
    repeat (6) @(posedge clock);
    runOp(3'h3, 2'h2, 1'b0, 4'h0, 4'h7, 16'h0000, 32'h0, 3);
    check16(outPins, 16'ha55a);
    pinsOf(4'h7, 16'h0ff0);
    // one word as both source and destination
    load(4'h3, 16'h0001);
    runOp(3'h4, 2'h0, 1'b0, 4'h3, 4'h3, 16'h0700, 32'h0, 3);
    pinsOf(4'h3, 16'h0081);
    load(4'h3, 16'h4321);
    runOp(3'h5, 2'h0, 1'b0, 4'h3, 4'h3, 16'h0031, 32'h0, 3);
    pinsOf(4'h3, 16'h1432);
    regChk(8'h10, 16'h1432);
    runOp(3'h4, 2'h0, 1'b0, 4'h3, 4'h3, 16'h0010, 32'h0, 3);
    regChk(8'h04, 16'h0004);
    // interrupt status, mask and clear on read
    regChk(8'h08, 16'h0003);
    regChk(8'h08, 16'h0000);
    regWr(8'h0c, 16'h0002);
    regChk(8'h0c, 16'h0002);
    load(4'h4, 16'h0000);
    repeat (3) @(posedge clock);
    check1(irq, 1'b0);
    runOp(3'h4, 2'h0, 1'b0, 4'h3, 4'h3, 16'h1000, 32'h0, 3);
    repeat (3) @(posedge clock);
    check1(irq, 1'b1);
    regChk(8'h08, 16'h0003);
    repeat (2) @(posedge clock);
    check1(irq, 1'b0);
    // disabled unit and illegal opcode refuse the request
    regWr(8'h00, 16'h0000);
    runOp(3'h0, 2'h1, 1'b0, 4'h0, 4'h5, 16'h0000, 32'h0, 0);
    regWr(8'h00, 16'h0001);
    runOp(3'h6, 2'h1, 1'b0, 4'h0, 4'h5, 16'h0000, 32'h0, 0);
    // reset after a finished faulting bit copy: fault flag, busy, pins, mask and irq cleared, then a request right after works
    runOp(3'h4, 2'h0, 1'b0, 4'h3, 4'h3, 16'h1000, 32'h0, 3);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    check1(faultIndicator, 1'b0);
    check1(irq, 1'b0);
    check1(opBusy, 1'b0);
    check16(outPins, 16'h0000);
    regChk(8'h0c, 16'h0000);
    fork
      load(4'h1, 16'h8000);
      begin
        repeat (3) @(posedge clock);
        #1;
        check1(opBusy, 1'b1);
      end
    join
    check1(signIndicator, 1'b1);
    stopTest();
  end
endmodule
`default_nettype wire

// >>> wbdmu_exec_model.sv
// execution-unit model: hands one operation at a time to the move unit
// assumes opDone of the move unit on the same clock; operands released between requests
`default_nettype none
module wbdmu_exec_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // operation request
  output logic opStart,
  output logic [2:0] opCode,
  output logic [1:0] opSrcSel,
  output logic opDstSel,
  output logic [3:0] opSrcAddr,
  output logic [3:0] opDstAddr,
  output logic [15:0] opCtrl,
  output logic [31:0] opLiteral,
  // operation status
  input wire logic opBusy,
  input wire logic opDone
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    opStart = 1'b0;
    {opCode, opSrcSel, opDstSel, opSrcAddr, opDstAddr, opCtrl, opLiteral} = '0;
  end
  // edges from the request edge until done shows, 0 when it never came
  task automatic issue(input logic [2:0] op, input logic [1:0] ss, input logic ds,
      input logic [3:0] sa, input logic [3:0] da, input logic [15:0] c,
      input logic [31:0] lit, output int edges);
    edges = 0;
    @(posedge clock);
    opStart <= 1'b1;
    {opCode, opSrcSel, opDstSel, opSrcAddr, opDstAddr, opCtrl, opLiteral} <=
      {op, ss, ds, sa, da, c, lit};
    @(posedge clock);
    opStart <= 1'b0;
    // released operands no longer carry the request
    {opCode, opSrcSel, opDstSel, opSrcAddr, opDstAddr, opCtrl, opLiteral} <=
      ~{op, ss, ds, sa, da, c, lit};
    for (int i = 1; i <= 12; i++) begin
      @(posedge clock);
      #1;
      if (opDone === 1'b1) begin
        edges = i;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> wbdmu_mem.sv
// sixteen data words; read data registered, one cycle after the address
// assumes the owner issues at most one access per cycle
`default_nettype none
module wbdmu_mem (
  // clock
  input wire logic clock,
  // access port
  wbdmu_mem_if.store port
);
  logic [15:0] words [0:15];

  always_ff @(posedge clock) begin
    if (port.writeEnable) begin
      words[port.addr] <= port.writeData;
    end
    port.readData <= words[port.addr];
  end
endmodule
`default_nettype wire

// >>> wbdmu_mem_if.sv
// port bundle between the move unit and its data word store
// assumes both ends run on the same clock
`default_nettype none
interface wbdmu_mem_if;
  logic [3:0] addr;
  logic [15:0] writeData;
  logic writeEnable;
  logic [15:0] readData;
  modport owner (output addr, output writeData, output writeEnable, input readData);
  modport store (input addr, input writeData, input writeEnable, output readData);
endinterface
`default_nettype wire

// >>> wbdmu_params.svh
// constants of the word, bit and digit move unit: offsets, fields, resets
// assumes a single clock domain and the plain register port of the top module
`ifndef WBDMU_PARAMS_SVH
`define WBDMU_PARAMS_SVH

`define WBDMU_ADDR_CTRL 8'h00
`define WBDMU_ADDR_FLAGS 8'h04
`define WBDMU_ADDR_IRQ_STATUS 8'h08
`define WBDMU_ADDR_IRQ_MASK 8'h0c
`define WBDMU_ADDR_RESULT 8'h10

`define WBDMU_CTRL_RESET 16'h0001
`define WBDMU_MASK_RESET 16'h0000
`define WBDMU_BIT_ENABLE 0
`define WBDMU_BIT_ZERO 0
`define WBDMU_BIT_SIGN 1
`define WBDMU_BIT_FAULT 2
`define WBDMU_IRQ_DONE 0
`define WBDMU_IRQ_FAULT 1

`define WBDMU_BIT_POS_MAX 8'h0f
`define WBDMU_DIGIT_MAX 4'h3

`endif

// >>> wbdmu_pkg.sv
// types of the word, bit and digit move unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package wbdmu_pkg;
  typedef enum logic [2:0] {
    OP_WORD_COPY = 3'h0,
    OP_DOUBLE_WORD_COPY = 3'h1,
    OP_COMPLEMENT_COPY = 3'h2,
    OP_IMMEDIATE_REFRESH_WORD_COPY = 3'h3,
    OP_SINGLE_BIT_COPY = 3'h4,
    OP_NIBBLE_COPY = 3'h5
  } wbdmu_op_type;
  typedef enum logic [1:0] {
    SRC_MEM = 2'h0,
    SRC_LITERAL = 2'h1,
    SRC_PINS = 2'h2
  } wbdmu_src_type;
  typedef enum logic {
    DST_MEM = 1'h0,
    DST_PINS = 1'h1
  } wbdmu_dst_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ_SRC = 3'h1,
    ST_READ_AUX = 3'h2,
    ST_WRITE_LO = 3'h3,
    ST_WRITE_HI = 3'h4,
    ST_DONE = 3'h5
  } wbdmu_state_type;
endpackage
`default_nettype wire

// >>> wbdmu_top.sv
// word, double word, complement, bit and digit move datapath with registers
// assumes a synchronous active high reset and pins from outside the clock domain
`include "wbdmu_params.svh"
`default_nettype none
module wbdmu_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // operation request
  input wire logic opStart,
  input wire logic [2:0] opCode,
  input wire logic [1:0] opSrcSel,
  input wire logic opDstSel,
  input wire logic [3:0] opSrcAddr,
  input wire logic [3:0] opDstAddr,
  input wire logic [15:0] opCtrl,
  input wire logic [31:0] opLiteral,
  // operation status
  output logic opBusy,
  output logic opDone,
  output logic zeroIndicator,
  output logic signIndicator,
  output logic faultIndicator,
  // physical pins
  input wire logic [15:0] inPins,
  output logic [15:0] outPins,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regReadData,
  // interrupt
  output logic irq
);
  wbdmu_mem_if memPort ();

  wbdmu_mem u_mem (
    .clock(clock),
    .port(memPort)
  );

  // bit copy: move bit n of src into bit m of dst, rest of dst kept
  function automatic logic [15:0] bitMove(input logic [15:0] src, input logic [15:0] dst,
                                          input logic [15:0] ctrl);
    logic [15:0] res;
    res = dst;
    res[ctrl[11:8]] = src[ctrl[3:0]];
    return res;
  endfunction

  // digit copy: upward with wrap on both words
  function automatic logic [15:0] digitMove(input logic [15:0] src, input logic [15:0] dst,
                                            input logic [15:0] ctrl);
    logic [15:0] res;
    logic [1:0] s;
    logic [1:0] d;
    res = dst;
    s = ctrl[1:0];
    d = ctrl[9:8];
    for (int i = 0; i < 4; i++) begin
      if (i <= int'(ctrl[5:4])) begin
        res[d*4 +: 4] = src[s*4 +: 4];
        s = s + 2'h1;
        d = d + 2'h1;
      end
    end
    return res;
  endfunction

  function automatic logic bitFault(input logic [15:0] ctrl);
    return (ctrl[7:0] > `WBDMU_BIT_POS_MAX) || (ctrl[15:8] > `WBDMU_BIT_POS_MAX);
  endfunction

  function automatic logic digitFault(input logic [15:0] ctrl);
    return (ctrl[3:0] > `WBDMU_DIGIT_MAX) || (ctrl[7:4] > `WBDMU_DIGIT_MAX) ||
           (ctrl[11:8] > `WBDMU_DIGIT_MAX);
  endfunction

  wbdmu_pkg::wbdmu_state_type state_r;
  wbdmu_pkg::wbdmu_state_type state_nxt;
  logic [2:0] op_r;
  wbdmu_pkg::wbdmu_src_type srcSel_r;
  wbdmu_pkg::wbdmu_dst_type dstSel_r;
  logic [3:0] srcAddr_r;
  logic [3:0] dstAddr_r;
  logic [15:0] ctrl_r;
  logic [31:0] literal_r;
  logic [15:0] pinSnap_r;
  logic [15:0] srcWord_r;
  logic [15:0] auxWord_r;
  logic [15:0] result_r;
  logic [15:0] pinSync1_r;
  logic [15:0] pinSync2_r;
  logic [15:0] pinSync3_r;
  logic [15:0] pinStable_r;
  logic [15:0] outPins_r;
  logic zero_r;
  logic sign_r;
  logic fault_r;
  logic [15:0] ctrlReg_r;
  logic [15:0] mask_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] rdData_r;

  // request decode
  wire logic enable = ctrlReg_r[`WBDMU_BIT_ENABLE];
  wire logic opLegal = opCode <= 3'(wbdmu_pkg::OP_NIBBLE_COPY);
  wire logic accept = opStart && (state_r == wbdmu_pkg::ST_IDLE) && enable && opLegal;
  wire logic isImmediate = opCode == 3'(wbdmu_pkg::OP_IMMEDIATE_REFRESH_WORD_COPY);
  wire logic reqLiteral = opSrcSel == 2'(wbdmu_pkg::SRC_LITERAL);
  wire logic reqPins = isImmediate && (opSrcSel == 2'(wbdmu_pkg::SRC_PINS));
  wire wbdmu_pkg::wbdmu_src_type reqSrc =
    reqPins ? wbdmu_pkg::SRC_PINS : (reqLiteral ? wbdmu_pkg::SRC_LITERAL : wbdmu_pkg::SRC_MEM);
  wire wbdmu_pkg::wbdmu_dst_type reqDst =
    (isImmediate && opDstSel) ? wbdmu_pkg::DST_PINS : wbdmu_pkg::DST_MEM;

  wire logic isDouble = op_r == 3'(wbdmu_pkg::OP_DOUBLE_WORD_COPY);
  wire logic isComplement = op_r == 3'(wbdmu_pkg::OP_COMPLEMENT_COPY);
  wire logic isBit = op_r == 3'(wbdmu_pkg::OP_SINGLE_BIT_COPY);
  wire logic isNibble = op_r == 3'(wbdmu_pkg::OP_NIBBLE_COPY);
  wire logic isWordClass = !isBit && !isNibble;
  wire logic opErr = (isBit && bitFault(ctrl_r)) || (isNibble && digitFault(ctrl_r));

  // result of the low write
  wire logic [15:0] resultLo =
    isComplement ? ~srcWord_r :
    isBit ? bitMove(srcWord_r, auxWord_r, ctrl_r) :
    isNibble ? digitMove(srcWord_r, auxWord_r, ctrl_r) :
    srcWord_r;

  // source capture
  wire logic [15:0] srcCapture =
    (srcSel_r == wbdmu_pkg::SRC_LITERAL) ? literal_r[15:0] :
    (srcSel_r == wbdmu_pkg::SRC_PINS) ? pinSnap_r : memPort.readData;
  wire logic [15:0] auxCapture =
    (isDouble && srcSel_r == wbdmu_pkg::SRC_LITERAL) ? literal_r[31:16] : memPort.readData;

  // memory access
  wire logic writeLo = state_r == wbdmu_pkg::ST_WRITE_LO;
  wire logic writeHi = state_r == wbdmu_pkg::ST_WRITE_HI;
  wire logic [3:0] auxAddr = isDouble ? 4'(srcAddr_r + 4'h1) : dstAddr_r;
  assign memPort.addr =
    (state_r == wbdmu_pkg::ST_IDLE) ? opSrcAddr :
    (state_r == wbdmu_pkg::ST_READ_SRC) ? auxAddr :
    writeHi ? 4'(dstAddr_r + 4'h1) : dstAddr_r;
  assign memPort.writeData = writeHi ? auxWord_r : resultLo;
  assign memPort.writeEnable = (writeLo && dstSel_r == wbdmu_pkg::DST_MEM && !opErr) || writeHi;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wbdmu_pkg::ST_IDLE: if (accept) state_nxt = wbdmu_pkg::ST_READ_SRC;
      wbdmu_pkg::ST_READ_SRC: state_nxt = wbdmu_pkg::ST_READ_AUX;
      wbdmu_pkg::ST_READ_AUX: state_nxt = wbdmu_pkg::ST_WRITE_LO;
      wbdmu_pkg::ST_WRITE_LO:
        state_nxt = isDouble ? wbdmu_pkg::ST_WRITE_HI : wbdmu_pkg::ST_DONE;
      wbdmu_pkg::ST_WRITE_HI: state_nxt = wbdmu_pkg::ST_DONE;
      wbdmu_pkg::ST_DONE: state_nxt = wbdmu_pkg::ST_IDLE;
      default: state_nxt = wbdmu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= wbdmu_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request latch; input pins are snapshot just before execution
  always_ff @(posedge clock) begin
    if (reset) begin
      op_r <= 3'h0;
      srcSel_r <= wbdmu_pkg::SRC_MEM;
      dstSel_r <= wbdmu_pkg::DST_MEM;
      srcAddr_r <= 4'h0;
      dstAddr_r <= 4'h0;
      ctrl_r <= 16'h0000;
      literal_r <= 32'h00000000;
      pinSnap_r <= 16'h0000;
    end else if (accept) begin
      op_r <= opCode;
      srcSel_r <= reqSrc;
      dstSel_r <= reqDst;
      srcAddr_r <= opSrcAddr;
      dstAddr_r <= opDstAddr;
      ctrl_r <= opCtrl;
      literal_r <= opLiteral;
      pinSnap_r <= pinStable_r;
    end
  end

  // operand capture; destination is read before any write, so src may equal dst
  always_ff @(posedge clock) begin
    if (reset) begin
      srcWord_r <= 16'h0000;
      auxWord_r <= 16'h0000;
    end else begin
      if (state_r == wbdmu_pkg::ST_READ_SRC) srcWord_r <= srcCapture;
      if (state_r == wbdmu_pkg::ST_READ_AUX) auxWord_r <= auxCapture;
    end
  end

  // pin synchroniser: a bit changes once stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      pinSync1_r <= 16'h0000;
      pinSync2_r <= 16'h0000;
      pinSync3_r <= 16'h0000;
      pinStable_r <= 16'h0000;
    end else begin
      pinSync1_r <= inPins;
      pinSync2_r <= pinSync1_r;
      pinSync3_r <= pinSync2_r;
      pinStable_r <= (~(pinSync2_r ^ pinSync3_r) & pinSync3_r) |
                     ((pinSync2_r ^ pinSync3_r) & pinStable_r);
    end
  end

  // output pins refreshed right after execution
  always_ff @(posedge clock) begin
    if (reset) begin
      outPins_r <= 16'h0000;
    end else if (writeLo && dstSel_r == wbdmu_pkg::DST_PINS) begin
      outPins_r <= resultLo;
    end
  end

  // result flags
  always_ff @(posedge clock) begin
    if (reset) begin
      zero_r <= 1'b0;
      sign_r <= 1'b0;
      fault_r <= 1'b0;
      result_r <= 16'h0000;
    end else if (writeLo && isWordClass && !isDouble) begin
      zero_r <= resultLo == 16'h0000;
      sign_r <= resultLo[15];
      fault_r <= 1'b0;
      result_r <= resultLo;
    end else if (writeLo && !isWordClass) begin
      fault_r <= opErr;
      if (!opErr) result_r <= resultLo;
    end else if (writeHi) begin
      zero_r <= {auxWord_r, srcWord_r} == 32'h00000000;
      sign_r <= auxWord_r[15];
      fault_r <= 1'b0;
      result_r <= srcWord_r;
    end
  end

  // register port
  wire logic regWriteCtrl = regWrite && regAddr == `WBDMU_ADDR_CTRL;
  wire logic regWriteMask = regWrite && regAddr == `WBDMU_ADDR_IRQ_MASK;
  wire logic statusRead = regRead && regAddr == `WBDMU_ADDR_IRQ_STATUS;
  wire logic [15:0] flagsWord = {13'h0000, fault_r, sign_r, zero_r};
  wire logic [15:0] eventSet =
    {14'h0000, (state_r == wbdmu_pkg::ST_DONE) && fault_r, state_r == wbdmu_pkg::ST_DONE};
  wire logic [15:0] readMux =
    (regAddr == `WBDMU_ADDR_CTRL) ? ctrlReg_r :
    (regAddr == `WBDMU_ADDR_FLAGS) ? flagsWord :
    (regAddr == `WBDMU_ADDR_IRQ_STATUS) ? status_r :
    (regAddr == `WBDMU_ADDR_IRQ_MASK) ? mask_r :
    (regAddr == `WBDMU_ADDR_RESULT) ? result_r : 16'h0000;

  // a read clears status, an event in the same cycle still lands
  assign status_nxt = (statusRead ? 16'h0000 : status_r) | eventSet;

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlReg_r <= `WBDMU_CTRL_RESET;
      mask_r <= `WBDMU_MASK_RESET;
      status_r <= 16'h0000;
      rdData_r <= 16'h0000;
    end else begin
      if (regWriteCtrl) ctrlReg_r <= {15'h0000, regWriteData[`WBDMU_BIT_ENABLE]};
      if (regWriteMask) mask_r <= {14'h0000, regWriteData[1:0]};
      status_r <= status_nxt;
      rdData_r <= regRead ? readMux : 16'h0000;
    end
  end

  assign opBusy = state_r != wbdmu_pkg::ST_IDLE;
  assign opDone = state_r == wbdmu_pkg::ST_DONE;
  assign zeroIndicator = zero_r;
  assign signIndicator = sign_r;
  assign faultIndicator = fault_r;
  assign outPins = outPins_r;
  assign regReadData = rdData_r;
  assign irq = |(status_r & mask_r);

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_word_copy;
    writeLo && op_r == 3'(wbdmu_pkg::OP_WORD_COPY) |->
      memPort.writeEnable && memPort.writeData == srcWord_r && memPort.addr == dstAddr_r;
  endproperty
  a_word_copy: assert property (p_word_copy) else $error("word copy data mismatch");

  property p_double_hi;
    writeLo && isDouble |=> writeHi && memPort.writeEnable &&
      memPort.addr == 4'($past(dstAddr_r) + 4'h1) && memPort.writeData == auxWord_r;
  endproperty
  a_double_hi: assert property (p_double_hi)
    else $error("double copy high word wrong");

  property p_complement;
    writeLo && isComplement |-> (memPort.writeData ^ srcWord_r) == 16'hffff;
  endproperty
  a_complement: assert property (p_complement) else $error("complement not inverted");

  property p_zero_flag;
    writeLo && isWordClass && !isDouble |=> zero_r == ($past(resultLo) == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_sign_flag;
    writeHi |=> sign_r == $past(auxWord_r[15]) && !fault_r;
  endproperty
  a_sign_flag: assert property (p_sign_flag) else $error("double sign flag wrong");

  property p_pin_out;
    writeLo && dstSel_r == wbdmu_pkg::DST_PINS |=> outPins == $past(resultLo) && opDone;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("output pins not refreshed");

  property p_bit_fault;
    writeLo && isBit |=> fault_r == ($past(ctrl_r[7:0]) > 8'h0f || $past(ctrl_r[15:8]) > 8'h0f);
  endproperty
  a_bit_fault: assert property (p_bit_fault) else $error("bit copy fault flag wrong");

  property p_bit_keep;
    writeLo && isBit && !opErr |->
      ((memPort.writeData ^ auxWord_r) & ~(16'h0001 << ctrl_r[11:8])) == 16'h0000 &&
      memPort.writeData[ctrl_r[11:8]] == srcWord_r[ctrl_r[3:0]];
  endproperty
  a_bit_keep: assert property (p_bit_keep)
    else $error("bit copy disturbed other bits");

  property p_digit_fault;
    writeLo && isNibble && opErr |-> !memPort.writeEnable ##1 fault_r ##1 status_r[1];
  endproperty
  a_digit_fault: assert property (p_digit_fault)
    else $error("digit fault not reported");

  property p_done_bound;
    accept |-> ##[4:5] opDone;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("operation did not finish");

  c_word: cover property (opDone && op_r == 3'(wbdmu_pkg::OP_WORD_COPY));
  c_immediate: cover property (writeLo && srcSel_r == wbdmu_pkg::SRC_PINS &&
                               dstSel_r == wbdmu_pkg::DST_PINS);
  c_nibble: cover property (writeLo && isNibble && ctrl_r[11:0] == 12'h031);
  c_bit_fault: cover property (writeLo && isBit && opErr);
endmodule
`default_nettype wire
